// >>> core/canopen_guard.sv
// CANopen guarding, heartbeat, PDO triggering and dictionary registers
`timescale 1ns/1ns
`default_nettype none
module canopen_guard
   import canopen_guard_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int NMOD = 13,
   parameter logic [31:0] VENDOR_ID = 32'h0000_0001, // Arbitrary value
   parameter logic [31:0] VARIANT_ID = 32'h0000_0002, // Arbitrary value
   parameter logic [31:0] REVISION_ID = 32'h0000_0003, // Arbitrary value
   parameter logic [31:0] SERIAL_ID = 32'h0000_0004 // Arbitrary value
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_B_I,
   // AHB-Lite slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // Received CAN frames
   input wire logic RXF_VALID_I,
   input wire logic [10:0] RXF_ID_I,
   input wire logic RXF_RTR_I,
   input wire logic [3:0] RXF_DLC_I,
   input wire logic [63:0] RXF_DATA_I,
   // Frames to send
   output logic TXF_VALID_O,
   input wire logic TXF_READY_I,
   output logic [10:0] TXF_ID_O,
   output logic [3:0] TXF_DLC_O,
   output logic [63:0] TXF_DATA_O,
   // Process data and module status
   input wire logic [NPDO*64-1:0] PROC_IN_I,
   output logic [NPDO*64-1:0] PROC_OUT_O,
   input wire logic [NMOD*32-1:0] MOD_STAT_I,
   // Indicators
   output logic CABLE_BREAK_O,
   output logic NET_LED_RED_O
);
   // ------------------------------------------------------------
   // Bus slave: one wait state so read data leave a flop
   // ------------------------------------------------------------
   logic ph_reg, wr_reg, hrdy_reg;
   logic [11:0] adr_reg;
   logic [31:0] hrd_reg, rdata;
   wire accept = HSEL_I & HREADY_I & HTRANS_I[1];
   wire we = ph_reg & wr_reg;
   wire [1:0] ix = adr_reg[3:2];

   // Address phase capture, data phase answer
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ph_reg <= 1'b0;
         wr_reg <= 1'b0;
         adr_reg <= 12'h000;
         hrdy_reg <= 1'b1;
         hrd_reg <= 32'h0000_0000;
      end else if (accept) begin
         ph_reg <= 1'b1;
         wr_reg <= HWRITE_I;
         adr_reg <= HADDR_I[11:0]; // Upper bits alias
         hrdy_reg <= 1'b0;
      end else if (ph_reg) begin
         ph_reg <= 1'b0;
         hrdy_reg <= 1'b1;
         hrd_reg <= wr_reg ? 32'h0000_0000 : rdata;
      end
   end
   assign HRDATA_O = hrd_reg;
   assign HREADYOUT_O = hrdy_reg;
   assign HRESP_O = 1'b0;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [6:0] node_reg;
   logic [15:0] cons_reg, prod_reg, guard_reg;
   logic [7:0] life_reg;
   logic [31:0] abort_reg;
   logic [7:0] ttype_reg [NPDO];
   logic [15:0] evt_reg [NPDO];
   wire sel_small = adr_reg[11:8] == 4'h0;
   wire [7:0] grp = {4'h0, adr_reg[7:4]};
   wire tt_ok = HWDATA_I[7:0] <= TT_SYNC_MAX || HWDATA_I[7:0] >= TT_RTR;

   // Software writes, with invalid settings refused
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         node_reg <= NODE_RST;
         cons_reg <= 16'h0000;
         prod_reg <= 16'h0000;
         guard_reg <= 16'h0000;
         life_reg <= 8'h00;
         abort_reg <= 32'h0000_0000;
         for (int k = 0; k < NPDO; k++) begin
            ttype_reg[k] <= TT_COS;
            evt_reg[k] <= 16'h0000;
         end
      end else if (we && sel_small) begin
         if (adr_reg == A_NODE) node_reg <= HWDATA_I[6:0];
         if (adr_reg == A_CONS) cons_reg <= HWDATA_I[15:0];
         if (adr_reg == A_PROD) prod_reg <= HWDATA_I[15:0];
         if (adr_reg == A_GUARD) guard_reg <= HWDATA_I[15:0];
         if (adr_reg == A_LIFE) life_reg <= HWDATA_I[7:0];
         if (adr_reg == A_ABORT) abort_reg <= 32'h0000_0000;
         if (grp == G_RXMODE && HWDATA_I[7:0] != RX_MODE_FIX) begin
            abort_reg <= ABORT_RX;
         end
         if (grp == G_TTYPE) begin
            if (tt_ok) begin
               ttype_reg[ix] <= HWDATA_I[7:0];
            end else begin
               abort_reg <= ABORT_TX;
            end
         end
         if (grp == G_EVT) evt_reg[ix] <= HWDATA_I[15:0];
      end
   end

   // ------------------------------------------------------------
   // Frame decode and communication reset
   // ------------------------------------------------------------
   wire [10:0] hb_id = ID_HB + {4'h0, node_reg};
   wire rx_data = RXF_VALID_I & ~RXF_RTR_I;
   wire sync = rx_data && RXF_ID_I == ID_SYNC;
   wire guard_msg = RXF_VALID_I && RXF_RTR_I && RXF_ID_I == hb_id;
   wire nmt_hit = RXF_DATA_I[15:8] == 8'h00 || RXF_DATA_I[15:8] == {1'b0, node_reg};
   wire comm_rst = (rx_data && RXF_ID_I == ID_NMT && RXF_DATA_I[7:0] == NMT_RST_COMM && nmt_hit)
                   || (we && adr_reg == A_CMD && HWDATA_I[0]);

   // ------------------------------------------------------------
   // Millisecond tick shared by all timers
   // ------------------------------------------------------------
   logic [31:0] tick_cnt;
   logic ms_tick;
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         tick_cnt <= 32'h0000_0000;
         ms_tick <= 1'b0;
      end else if (comm_rst) begin
         tick_cnt <= 32'h0000_0000;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= tick_cnt == 32'(TICK_CYCLES - 1);
         tick_cnt <= tick_cnt == 32'(TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      end
   end

   // ------------------------------------------------------------
   // Supervision: heartbeat consumer or life guarding
   // ------------------------------------------------------------
   wire [23:0] lg_ms = guard_reg * life_reg;
   wire lg_en = lg_ms != 24'h000000 && prod_reg == 16'h0000;
   wire cons_en = cons_reg != 16'h0000;
   logic lg_arm, brk_reg;
   logic [23:0] sup_cnt;
   wire [23:0] sup_lim = cons_en ? {8'h00, cons_reg} : lg_ms;
   wire sup_on = cons_en | (lg_en & lg_arm);
   wire brk_set = ms_tick && sup_on && !brk_reg && !guard_msg && sup_cnt + 24'h000001 >= sup_lim;

   // Idle time since the last guarding message
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         lg_arm <= 1'b0;
         sup_cnt <= 24'h000000;
         brk_reg <= 1'b0;
      end else if (comm_rst) begin
         lg_arm <= 1'b0;
         sup_cnt <= 24'h000000;
         brk_reg <= brk_set; // A timeout in the reset cycle still wins
      end else begin
         if (guard_msg && lg_en) lg_arm <= 1'b1;
         if (!lg_en) lg_arm <= 1'b0;
         if (guard_msg || !sup_on) begin
            sup_cnt <= 24'h000000;
         end else if (ms_tick && !brk_reg) begin
            sup_cnt <= sup_cnt + 24'h000001;
         end
         if (brk_set) brk_reg <= 1'b1;
      end
   end
   assign CABLE_BREAK_O = brk_reg;

   // Red flash while the break stands
   logic [15:0] fl_cnt;
   logic led_reg;
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         fl_cnt <= 16'h0000;
         led_reg <= 1'b0;
      end else if (!brk_reg) begin
         fl_cnt <= FLASH_MS - 16'h0001; // Wrap point, so the first break tick lights red
         led_reg <= 1'b0;
      end else if (ms_tick) begin
         fl_cnt <= fl_cnt + 16'h0001 >= FLASH_MS ? 16'h0000 : fl_cnt + 16'h0001;
         if (fl_cnt + 16'h0001 >= FLASH_MS) led_reg <= ~led_reg;
      end
   end
   assign NET_LED_RED_O = led_reg;

   // ------------------------------------------------------------
   // Heartbeat producer
   // ------------------------------------------------------------
   wire [16:0] hb_per = ({1'b0, prod_reg} + HB_ROUND) & ~HB_ROUND;
   logic [16:0] hb_cnt;
   logic hb_pend, gnt_hb;
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         hb_cnt <= 17'h00000;
         hb_pend <= 1'b0;
      end else if (comm_rst || prod_reg == 16'h0000) begin
         hb_cnt <= 17'h00000;
         hb_pend <= 1'b0;
      end else if (ms_tick && hb_cnt + 17'h00001 >= hb_per) begin
         hb_cnt <= 17'h00000;
         hb_pend <= 1'b1;
      end else begin
         if (ms_tick) hb_cnt <= hb_cnt + 17'h00001;
         if (gnt_hb) hb_pend <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // TxPDO triggers, one set per PDO
   // ------------------------------------------------------------
   logic [NPDO-1:0] pend, gnt;
   genvar g;
   generate
      for (g = 0; g < NPDO; g++) begin : g_tx
         logic [63:0] last, prev;
         logic [7:0] scnt;
         logic [15:0] ecnt;
         logic pnd;
         wire [63:0] dat = PROC_IN_I[64*g +: 64];
         wire [7:0] tt = ttype_reg[g];
         wire [15:0] ev = evt_reg[g];
         wire [10:0] cob = 11'(ID_TXB + ID_STEP * g) + {4'h0, node_reg};
         wire ntype = tt != 8'h00 && tt <= TT_SYNC_MAX;
         wire tmr = tt >= TT_ASYN && ev != 16'h0000;
         wire ev_hit = tmr && ms_tick && ecnt + 16'h0001 >= ev;
         wire rtr = RXF_VALID_I && RXF_RTR_I && RXF_DLC_I == 4'h0 && RXF_ID_I == cob;
         wire set = (tt == 8'h00 && sync && dat != last)
                    || (ntype && sync && scnt + 8'h01 == tt)
                    || (tt == TT_COS && ev == 16'h0000 && dat != prev)
                    || ev_hit
                    || (tt == TT_RTR && rtr);
         always_ff @(posedge CLK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
               last <= 64'h0;
               prev <= 64'h0;
               scnt <= 8'h00;
               ecnt <= 16'h0000;
               pnd <= 1'b0;
            end else begin
               prev <= dat;
               if (gnt[g]) last <= dat;
               if (comm_rst || !ntype) begin
                  scnt <= 8'h00;
               end else if (sync) begin
                  scnt <= scnt + 8'h01 == tt ? 8'h00 : scnt + 8'h01;
               end
               if (comm_rst || !tmr) begin
                  ecnt <= 16'h0000;
               end else if (ms_tick) begin
                  ecnt <= ev_hit ? 16'h0000 : ecnt + 16'h0001;
               end
               // A new trigger beats the grant that clears it
               if (comm_rst) pnd <= 1'b0;
               else if (set) pnd <= 1'b1;
               else if (gnt[g]) pnd <= 1'b0;
            end
         end
         assign pend[g] = pnd;
      end
   endgenerate

   // ------------------------------------------------------------
   // Transmit arbiter: heartbeat first, then lowest PDO
   // ------------------------------------------------------------
   logic txv_reg;
   logic [10:0] txid_reg;
   logic [3:0] txdlc_reg;
   logic [63:0] txd_reg;
   always_comb begin
      gnt_hb = !txv_reg && hb_pend;
      gnt = '0;
      for (int k = NPDO - 1; k >= 0; k--) begin
         if (!txv_reg && !hb_pend && pend[k]) gnt = NPDO'(1 << k);
      end
   end

   // Frame register held until the controller takes it
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         txv_reg <= 1'b0;
         txid_reg <= 11'h000;
         txdlc_reg <= 4'h0;
         txd_reg <= 64'h0;
      end else if (txv_reg) begin
         if (TXF_READY_I) txv_reg <= 1'b0;
      end else if (gnt_hb) begin
         txv_reg <= 1'b1;
         txid_reg <= hb_id;
         txdlc_reg <= 4'h1;
         txd_reg <= {56'h0, HB_STATE};
      end else begin
         for (int k = 0; k < NPDO; k++) begin
            if (gnt[k]) begin
               txv_reg <= 1'b1;
               txid_reg <= 11'(ID_TXB + ID_STEP * k) + {4'h0, node_reg};
               txdlc_reg <= 4'h8;
               txd_reg <= PROC_IN_I[64*k +: 64];
            end
         end
      end
   end
   assign TXF_VALID_O = txv_reg;
   assign TXF_ID_O = txid_reg;
   assign TXF_DLC_O = txdlc_reg;
   assign TXF_DATA_O = txd_reg;

   // ------------------------------------------------------------
   // RxPDO data toward the outputs
   // ------------------------------------------------------------
   logic [NPDO*64-1:0] rxd_reg;
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rxd_reg <= '0;
      end else if (brk_set) begin
         rxd_reg <= '0;
      end else begin
         for (int k = 0; k < NPDO; k++) begin
            if (rx_data && RXF_ID_I == 11'(ID_RXB + ID_STEP * k) + {4'h0, node_reg}) begin
               rxd_reg[64*k +: 64] <= RXF_DATA_I;
            end
         end
         if (we && adr_reg[11:8] == P_PIN && adr_reg[7:5] == 3'h0) begin
            rxd_reg[32*adr_reg[4:2] +: 32] <= HWDATA_I;
         end
      end
   end
   assign PROC_OUT_O = rxd_reg;

   // ------------------------------------------------------------
   // Read multiplexer; unmapped words read zero
   // ------------------------------------------------------------
   wire [5:0] sub = adr_reg[7:2];
   always_comb begin
      rdata = 32'h0000_0000;
      if (sel_small) begin
         if (adr_reg == A_NODE) rdata = {25'h0, node_reg};
         if (adr_reg == A_CONS) rdata = {16'h0, cons_reg};
         if (adr_reg == A_PROD) rdata = {16'h0, prod_reg};
         if (adr_reg == A_GUARD) rdata = {16'h0, guard_reg};
         if (adr_reg == A_LIFE) rdata = {24'h0, life_reg};
         if (adr_reg == A_STAT) rdata = {28'h0, lg_arm, cons_en, hb_pend | (prod_reg != 16'h0000), brk_reg};
         if (adr_reg == A_ABORT) rdata = abort_reg;
         if (grp == G_RXMODE) rdata = {24'h0, RX_MODE_FIX};
         if (grp == G_TTYPE) rdata = {24'h0, ttype_reg[ix]};
         if (grp == G_EVT) rdata = {16'h0, evt_reg[ix]};
         if (grp == G_IDENT) begin
            unique case (ix)
               2'h0: rdata = VENDOR_ID;
               2'h1: rdata = VARIANT_ID;
               2'h2: rdata = REVISION_ID;
               2'h3: rdata = SERIAL_ID;
            endcase
         end
         if (grp == G_RXCOB) rdata = {21'h0, 11'(ID_RXB + ID_STEP * ix) + {4'h0, node_reg}};
         if (grp == G_TXCOB) rdata = {21'h0, 11'(ID_TXB + ID_STEP * ix) + {4'h0, node_reg}};
      end else if (adr_reg[11:8] == P_MODST) begin
         if (sub >= 6'h01 && sub <= 6'h03) rdata = MOD_STAT_I[31:0];
         else if (sub >= 6'h04 && 32'(sub) - 3 < NMOD) rdata = MOD_STAT_I[32*(sub-6'h03) +: 32];
      end else if (adr_reg[11:8] == P_POUT && adr_reg[7:5] == 3'h0) begin
         rdata = PROC_IN_I[32*adr_reg[4:2] +: 32];
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_HB_OFF: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      prod_reg == 16'h0000 |=> !hb_pend) else $error("heartbeat pending while disabled");
   AST_HB_ID: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      gnt_hb |=> TXF_VALID_O && TXF_ID_O == 11'h700 + {4'h0, $past(node_reg)} && TXF_DLC_O == 4'h1)
      else $error("heartbeat frame identifier wrong");
   AST_ROUND: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      prod_reg != 16'h0000 |-> hb_per[1:0] == 2'h0 && hb_per >= {1'b0, prod_reg} && hb_per < {1'b0, prod_reg} + 17'h4)
      else $error("heartbeat period not rounded to 4 ms");
   AST_BREAK: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      $rose(brk_reg) |-> PROC_OUT_O == '0 ##1 CABLE_BREAK_O) else $error("break did not clear data");
   AST_EXCL: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      !(lg_arm && prod_reg != 16'h0000)) else $error("life guarding with heartbeat");
   AST_RXABORT: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      we && grp == G_RXMODE && sel_small && HWDATA_I[7:0] != 8'hFF |=> abort_reg == 32'h0609_0030)
      else $error("receive mode abort missing");
   AST_TTYPE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      ttype_reg[0] <= 8'hF0 || ttype_reg[0] >= 8'hFD) else $error("invalid transmission type stored");
   AST_SYNC0: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      ttype_reg[0] == 8'h00 && sync && PROC_IN_I[63:0] == g_tx[0].last && !pend[0] && !comm_rst |=> !pend[0])
      else $error("type 0 sent without change");
   AST_TICK: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      comm_rst |=> tick_cnt == 32'h0 && !ms_tick ##1 !ms_tick) else $error("tick not cleared by reset");
endmodule
`default_nettype wire

// >>> core/canopen_guard_pkg.sv
// Constants for the CANopen guarding and PDO dictionary block
package canopen_guard_pkg;
   // ------------------------------------------------------------
   // Timing and PDO count
   // ------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam logic [15:0] FLASH_MS = 16'h00FA;
   localparam logic [16:0] HB_ROUND = 17'h00003;
   localparam int NPDO = 4;
   // ------------------------------------------------------------
   // Register byte offsets, group codes and page codes
   // ------------------------------------------------------------
   localparam logic [11:0] A_NODE = 12'h000;
   localparam logic [11:0] A_CMD = 12'h004;
   localparam logic [11:0] A_CONS = 12'h008;
   localparam logic [11:0] A_PROD = 12'h00C;
   localparam logic [11:0] A_GUARD = 12'h010;
   localparam logic [11:0] A_LIFE = 12'h014;
   localparam logic [11:0] A_STAT = 12'h018;
   localparam logic [11:0] A_ABORT = 12'h01C;
   localparam logic [7:0] G_RXMODE = 8'h02;
   localparam logic [7:0] G_TTYPE = 8'h03;
   localparam logic [7:0] G_EVT = 8'h04;
   localparam logic [7:0] G_IDENT = 8'h05;
   localparam logic [7:0] G_RXCOB = 8'h06;
   localparam logic [7:0] G_TXCOB = 8'h07;
   localparam logic [3:0] P_MODST = 4'h1;
   localparam logic [3:0] P_PIN = 4'h2;
   localparam logic [3:0] P_POUT = 4'h3;
   // Status bits
   localparam int ST_BRK = 0;
   localparam int ST_HB = 1;
   localparam int ST_CONS = 2;
   localparam int ST_LG = 3;
   // ------------------------------------------------------------
   // CAN identifiers, codes and reset values
   // ------------------------------------------------------------
   localparam logic [10:0] ID_NMT = 11'h000;
   localparam logic [10:0] ID_SYNC = 11'h080;
   localparam logic [10:0] ID_HB = 11'h700;
   localparam logic [10:0] ID_TXB = 11'h180;
   localparam logic [10:0] ID_RXB = 11'h200;
   localparam logic [10:0] ID_STEP = 11'h100;
   localparam logic [7:0] NMT_RST_COMM = 8'h82;
   localparam logic [7:0] HB_STATE = 8'h05;
   localparam logic [31:0] ABORT_RX = 32'h0609_0030;
   localparam logic [31:0] ABORT_TX = 32'h0030_0030;
   localparam logic [7:0] TT_SYNC_MAX = 8'hF0;
   localparam logic [7:0] TT_RTR = 8'hFD;
   localparam logic [7:0] TT_ASYN = 8'hFE;
   localparam logic [7:0] TT_COS = 8'hFF;
   localparam logic [7:0] RX_MODE_FIX = 8'hFF;
   localparam logic [6:0] NODE_RST = 7'h01;
endpackage

// >>> test/can_peer.sv
// CAN controller and NMT master model facing the guard block
`timescale 1ns/1ns
`default_nettype none
module can_peer (
   // Clock and stall mode
   input wire logic clk_i,
   input wire logic slow_i,
   // Frames from the block
   input wire logic tv_i,
   input wire logic [10:0] tid_i,
   input wire logic [3:0] tdlc_i,
   input wire logic [63:0] td_i,
   output logic tr_o,
   // Frames to the block
   output logic rv_o,
   output logic [10:0] rid_o,
   output logic rrtr_o,
   output logic [3:0] rdlc_o,
   output logic [63:0] rd_o
);
   logic [14:0] qid[$];
   logic [63:0] qd[$];
   int qt[$];
   int cyc = 0;
   int w = 0;
   initial begin
      {tr_o, rv_o, rid_o, rrtr_o, rdlc_o, rd_o} = '0;
   end
   // Take frames; a slow peer stalls ready four cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      w <= (tv_i && !tr_o) ? w + 1 : 0;
      tr_o <= tv_i && !tr_o && (!slow_i || w == 3);
      if (tv_i && tr_o) begin
         qid.push_back({tdlc_i, tid_i});
         qd.push_back(td_i);
         qt.push_back(cyc);
      end
   end
   // One-cycle frame; idle id and data lines show the inverse so stale data never match
   task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc, input logic [63:0] d);
      @(posedge clk_i);
      {rv_o, rid_o, rrtr_o, rdlc_o, rd_o} <= {1'b1, id, rtr, dlc, d};
      @(posedge clk_i);
      {rv_o, rid_o, rd_o} <= {1'b0, ~id, ~d};
   endtask
endmodule
`default_nettype wire

// >>> test/canopen_guard_tb_top.sv
// Self-checking bench for the CANopen guard block
`timescale 1ns/1ns
`default_nettype none
module canopen_guard_tb_top;
   import canopen_guard_pkg::*;
   localparam int TK = 10;
   logic clk = 0, rst_b = 0, hsel = 0, hwr = 0, slow = 0, ok;
   logic [1:0] htr = 0;
   logic [31:0] ha = 0, hwd = 0, hrd, rd, rnd = 32'h0000002A;
   logic hrdy, hresp, tv, tr, rv, rrtr, brk, led;
   logic [10:0] tid, rid;
   logic [3:0] tdlc, rdlc;
   logic [63:0] td, rdat;
   logic [255:0] pin, pout;
   logic [415:0] mst;
   int failures = 0, check_count = 0, ty = 255;
   int tt[7] = '{241, 0, 240, 252, 253, 254, 2};
   canopen_guard #(.TICK_CYCLES(TK)) DUT (.CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(ha),
      .HTRANS_I(htr), .HWRITE_I(hwr), .HSIZE_I(3'h2), .HWDATA_I(hwd), .HREADY_I(hrdy), .HRDATA_O(hrd),
      .HREADYOUT_O(hrdy), .HRESP_O(hresp), .RXF_VALID_I(rv), .RXF_ID_I(rid), .RXF_RTR_I(rrtr),
      .RXF_DLC_I(rdlc), .RXF_DATA_I(rdat), .TXF_VALID_O(tv), .TXF_READY_I(tr), .TXF_ID_O(tid),
      .TXF_DLC_O(tdlc), .TXF_DATA_O(td), .PROC_IN_I(pin), .PROC_OUT_O(pout), .MOD_STAT_I(mst),
      .CABLE_BREAK_O(brk), .NET_LED_RED_O(led));
   can_peer PEER (.clk_i(clk), .slow_i(slow), .tv_i(tv), .tid_i(tid), .tdlc_i(tdlc), .td_i(td),
      .tr_o(tr), .rv_o(rv), .rid_o(rid), .rrtr_o(rrtr), .rdlc_o(rdlc), .rd_o(rdat));
   // Clock and a hard ceiling on run length
   initial begin
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      summarize();
   end
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize;
      if (failures == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Bounded wait for hready at an edge
   task automatic rdy;
      int n;
      n = 0;
      do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 20);
      if (n == 20) begin failures++; summarize(); end
   endtask
   // Single word transfer; read data taken at the data-phase edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {hsel, htr, hwr, ha} <= {1'b1, 2'h2, w, 20'h0, a};
      rdy();
      {htr, hwd} <= {2'h0, d};
      rdy();
      rd = hrd;
      chk("hresp", hresp, 0);
   endtask
   task automatic wq(input int k);
      int n;
      for (n = 0; n < 3000 && PEER.qid.size() < k; n++) @(posedge clk);
      if (n == 3000) begin failures++; summarize(); end
   endtask
   task automatic clr;
      PEER.qid.delete();
      PEER.qd.delete();
      PEER.qt.delete();
   endtask
   task automatic fr(input logic [10:0] id, input logic [63:0] d);
      chk("tx id", PEER.qid[0], {4'h8, id});
      chk("tx data", PEER.qd[0], d);
   endtask
   // Main sequence
   initial begin
      for (int i = 0; i < 13; i++) begin
         rnd = nx(rnd);
         mst[32*i+:32] = rnd;
      end
      pin = {8{rnd}};
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      bus(0, 12'h030, 0); chk("type rst", rd, TT_COS);
      for (int i = 0; i < 4; i++) begin
         bus(0, 12'h050 + 12'(4 * i), 0); chk("ident", rd, i + 1);
      end
      bus(0, 12'h064, 0); chk("rx cob", rd, ID_RXB + ID_STEP + NODE_RST);
      bus(0, 12'h104, 0); chk("mod0", rd, mst[31:0]);
      bus(0, 12'h110, 0); chk("mod1", rd, mst[63:32]);
      bus(0, 12'h304, 0); chk("pout reg", rd, pin[63:32]);
      bus(1, 12'h200, rnd); chk("pin wr", pout[31:0], rnd);
      bus(0, 12'h200, 0); chk("pin rd", rd, 0);
      bus(0, 12'hFF0, 0); chk("unmapped", rd, 0);
      foreach (tt[i]) begin
         bus(1, A_ABORT, 0);
         bus(1, 12'h030, tt[i]);
         bus(0, A_ABORT, 0);
         ok = tt[i] <= 240 || tt[i] >= 253;
         chk("abort tx", rd, ok ? 0 : ABORT_TX);
         if (ok) ty = tt[i];
         bus(0, 12'h030, 0); chk("type", rd, ty);
      end
      bus(1, 12'h020, 0);
      bus(0, A_ABORT, 0); chk("abort rx", rd, ABORT_RX);
      bus(0, 12'h020, 0); chk("rx mode", rd, RX_MODE_FIX);
      // Type 2 sends on every second sync only
      clr();
      repeat (4) PEER.send(ID_SYNC, 0, 0, 0);
      wq(2);
      repeat (40) @(posedge clk);
      chk("sync n", PEER.qid.size(), 2);
      fr(ID_TXB + NODE_RST, pin[63:0]);
      // Remote request answered against a stalling controller
      bus(1, 12'h034, TT_RTR);
      clr();
      slow <= 1'b1;
      PEER.send(ID_TXB + ID_STEP + NODE_RST, 1, 0, 0);
      wq(1);
      fr(ID_TXB + ID_STEP + NODE_RST, pin[127:64]);
      clr();
      rnd = nx(rnd);
      pin[191:128] <= {rnd, ~rnd};
      wq(1);
      repeat (30) @(posedge clk);
      chk("cos n", PEER.qid.size(), 1);
      fr(ID_TXB + 2 * ID_STEP + NODE_RST, {rnd, ~rnd});
      bus(1, 12'h04C, 3);
      clr();
      wq(3);
      chk("evt", PEER.qt[2] - PEER.qt[1], 3 * TK);
      bus(1, 12'h04C, 0);
      // Heartbeat period rounded up to a multiple of 4 ms
      bus(1, A_PROD, 5);
      clr();
      wq(3);
      chk("hb id", PEER.qid[1], {4'h1, ID_HB + NODE_RST});
      chk("hb state", PEER.qd[1][7:0], HB_STATE);
      chk("hb per", PEER.qt[2] - PEER.qt[1], (5 + 3) / 4 * 4 * TK);
      bus(1, A_PROD, 0);
      repeat (20) @(posedge clk);
      clr();
      repeat (200) @(posedge clk);
      chk("hb off", PEER.qid.size(), 0);
      rnd = nx(rnd);
      PEER.send(ID_RXB + NODE_RST, 0, 8, {rnd, ~rnd});
      repeat (2) @(posedge clk);
      chk("rxpdo", pout[63:0], {rnd, ~rnd});
      // Type 0 sends on sync only after a data change
      bus(1, 12'h030, 0);
      clr();
      PEER.send(ID_SYNC, 0, 0, 0);
      repeat (30) @(posedge clk);
      chk("sync0 same", PEER.qid.size(), 0);
      rnd = nx(rnd);
      pin[63:0] <= {~rnd, rnd};
      PEER.send(ID_SYNC, 0, 0, 0);
      wq(1);
      fr(ID_TXB + NODE_RST, {~rnd, rnd});
      // Consumer supervision, then silence until break
      bus(1, A_CONS, 3);
      repeat (5) begin
         PEER.send(ID_HB + NODE_RST, 1, 0, 0);
         repeat (15) @(posedge clk);
      end
      chk("no brk", brk, 0);
      repeat (60) @(posedge clk);
      chk("brk", brk, 1);
      chk("pout clr", pout, 0);
      chk("led", led, 1);
      bus(1, A_CMD, 1); chk("comm rst", brk, 0);
      bus(1, A_CONS, 0);
      bus(1, A_GUARD, 2);
      bus(1, A_LIFE, 2);
      PEER.send(ID_HB + NODE_RST, 1, 0, 0);
      repeat (20) @(posedge clk);
      chk("lg early", brk, 0);
      repeat (50) @(posedge clk);
      chk("lg brk", brk, 1);
      PEER.send(ID_NMT, 0, 2, {48'h0, 8'h00, NMT_RST_COMM});
      repeat (2) @(posedge clk);
      chk("nmt rst", brk, 0);
      summarize();
   end
endmodule
`default_nettype wire
